// [logic/bslc_engine.sv]
// Purpose: brushless motor timing engine: pwm master, decoder, speed loop
// Assumes: all pins synchronous to ref_clk, cpu commutes phases via phaseOn
// Notes: one service runs at a time; phase duty waits for frame end
`timescale 1ns/1ps
`default_nettype none

module bslc_engine import bslc_pkg::*; #(
  parameter int PERIOD_CYC = PWM_PERIOD_CYC,
  parameter int SC_DIV = SC_PERIOD_DIV,
  parameter int LEAD_CYC = UPDATE_LEAD_CYC,
  parameter int SC_START = SC_START_CYC,
  parameter int REV_W = REV_CNT_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic driveEnable, // pwm and speed loop running
  input wire logic loopClosed, // 0: ramp drives voltage directly
  input wire logic complPairs, // phases as complementary pairs
  input wire logic [2:0] phaseOn, // commutation state from cpu
  input wire logic signed [23:0] speedRequired, // ramp input
  input wire logic signed [23:0] rampStep, // max change per run
  input wire logic signed [23:0] gainP, // 9.15
  input wire logic signed [23:0] gainI, // 9.15
  input wire logic signed [23:0] speedScale,
  input wire logic qdPhaseA,
  input wire logic qdPhaseB,
  input wire logic qdIndex,
  input wire logic [23:0] posMatchA, // position_match_value one
  input wire logic [23:0] posMatchB, // position_match_value two
  input wire logic posIrqClear,
  input wire logic faultIn, // overcurrent, active high
  input wire logic [2:0] faultMask, // phases cut by fault
  input wire logic faultIrqClear,
  input wire logic [2:0] gpioMode,
  input wire logic gpioIn,
  input wire logic gpioRequest,
  output logic [2:0] pwmBase,
  output logic [2:0] pwmCompl,
  output logic scActivity,
  output logic masterActivity,
  output logic [23:0] position,
  output logic direction,
  output logic [REV_W-1:0] revCount,
  output logic signed [23:0] measuredSpeed,
  output logic signed [23:0] appliedVoltage,
  output logic posIrq,
  output logic faultIrq,
  output logic gpioOut,
  output logic gpioOe_n,
  output logic gpioValue
);

  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] UPD_CNT = CNT_W'(PERIOD_CYC - 1 - LEAD_CYC);
  localparam logic [CNT_W-1:0] SC_CNT = CNT_W'(SC_START);
  localparam logic [CNT_W-1:0] HALF = CNT_W'(PERIOD_CYC / 2);
  localparam logic [7:0] SC_LAST = 8'(SC_DIV - 1);

  // saturate a wide signed value into 1.23
  function automatic logic signed [23:0] sat24(input logic signed [47:0] v);
    if (v > 48'sh0000007fffff) begin
      return 24'sh7fffff;
    end else if (v < 48'shffffff800000) begin
      return 24'sh800000;
    end else begin
      return v[23:0];
    end
  endfunction

  // ----------------------------------------
  // frame timing
  // ----------------------------------------
  logic [CNT_W-1:0] frameCnt_q; // position in pwm frame
  logic frameEnd; // last cycle of frame
  logic [7:0] scDiv_q; // frames since last speed run

  assign frameEnd = (frameCnt_q == LAST_CNT);

  // free running frame counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCnt_q <= DUTY_RST;
    end else begin
      frameCnt_q <= frameEnd ? DUTY_RST : frameCnt_q + 9'h001;
    end
  end

  // frame divider for the speed loop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scDiv_q <= 8'h00;
    end else if (frameEnd) begin
      scDiv_q <= (scDiv_q == SC_LAST) ? 8'h00 : scDiv_q + 8'h01;
    end
  end

  // ----------------------------------------
  // service requests and engine
  // ----------------------------------------
  bslc_state_e state_q; // current service
  logic scReq_q; // speed run pending
  logic updReq_q; // master update pending
  logic scTrig; // speed run due
  logic updTrig; // master update due
  logic takeUpd; // grant master update
  logic takeSc; // grant speed run
  logic voltNew_q; // fresh voltage waiting for update

  // speed run lands earlier in frame than the update
  assign scTrig = driveEnable && (frameCnt_q == SC_CNT) && (scDiv_q == 8'h00);
  assign updTrig = driveEnable && (frameCnt_q == UPD_CNT);
  // update first: its lead covers the longest speed run
  assign takeUpd = (state_q == ST_IDLE) && updReq_q;
  assign takeSc = (state_q == ST_IDLE) && !updReq_q && scReq_q;

  // pending flags, a new request wins over its grant
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scReq_q <= 1'b0;
      updReq_q <= 1'b0;
    end else begin
      scReq_q <= scTrig | (scReq_q & ~takeSc);
      updReq_q <= updTrig | (updReq_q & ~takeUpd);
    end
  end

  // non-preemptive service sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (takeUpd) begin
            state_q <= voltNew_q ? ST_MS_WRITE : ST_MS_UPD;
          end else if (takeSc) begin
            state_q <= ST_SC_MEAS;
          end
        end
        ST_SC_MEAS: state_q <= ST_SC_RAMP;
        ST_SC_RAMP: state_q <= ST_SC_PI;
        ST_SC_PI: state_q <= ST_MS_ACCEPT;
        ST_MS_ACCEPT: state_q <= ST_IDLE;
        ST_MS_WRITE: state_q <= ST_MS_UPD; // wide pulse when rewriting
        ST_MS_UPD: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // activity pins decode the service register directly, no pin needed
  assign scActivity = (state_q == ST_SC_MEAS) || (state_q == ST_SC_RAMP) ||
                      (state_q == ST_SC_PI);
  assign masterActivity = (state_q == ST_MS_ACCEPT) || (state_q == ST_MS_WRITE) ||
                          (state_q == ST_MS_UPD);

  // ----------------------------------------
  // quadrature decoder
  // ----------------------------------------
  logic [1:0] qdPrev_q; // last a,b
  logic idxPrev_q; // last index level
  logic [23:0] pos_q; // position counter
  logic dir_q; // 1 forward
  logic [REV_W-1:0] rev_q; // revolution counter
  logic [23:0] timer_q; // free timestamp base
  logic [23:0] lastEdge_q; // time of last count
  logic [23:0] prevEdge_q; // edge time at previous speed run
  logic signed [23:0] pcSc_q; // counts since previous speed run
  logic step; // one count this cycle
  logic up; // count direction
  logic [23:0] posNext; // counter after this cycle
  logic scRead; // speed run takes the count

  // exactly one input changed means a valid count
  assign step = (qdPhaseA ^ qdPrev_q[1]) ^ (qdPhaseB ^ qdPrev_q[0]);
  assign up = qdPrev_q[1] ^ qdPhaseB;
  assign posNext = step ? (up ? pos_q + 24'h000001 : pos_q - 24'h000001) : pos_q;
  assign scRead = (state_q == ST_SC_MEAS);

  // position, direction and edge time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qdPrev_q <= 2'h0;
      pos_q <= WORD_RST;
      dir_q <= 1'b1;
      timer_q <= WORD_RST;
      lastEdge_q <= WORD_RST;
    end else begin
      qdPrev_q <= {qdPhaseA, qdPhaseB};
      timer_q <= timer_q + 24'h000001;
      pos_q <= posNext;
      if (step) begin
        dir_q <= up;
        lastEdge_q <= timer_q;
      end
    end
  end

  // count since last run; a count in the read cycle is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcSc_q <= 24'sh000000;
      prevEdge_q <= WORD_RST;
    end else begin
      pcSc_q <= (scRead ? 24'sh000000 : pcSc_q) +
                (step ? (up ? 24'sh000001 : 24'shffffff) : 24'sh000000);
      if (scRead) begin
        prevEdge_q <= lastEdge_q;
      end
    end
  end

  // revolution counter on index rising edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idxPrev_q <= 1'b0;
      rev_q <= '0;
    end else begin
      idxPrev_q <= qdIndex;
      if (qdIndex && !idxPrev_q) begin
        rev_q <= dir_q ? rev_q + 1'b1 : rev_q - 1'b1;
      end
    end
  end

  // position interrupt, a new match wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      posIrq <= 1'b0;
    end else begin
      posIrq <= (step && (posNext == posMatchA || posNext == posMatchB)) ||
                (posIrq && !posIrqClear);
    end
  end

  assign position = pos_q;
  assign direction = dir_q;
  assign revCount = rev_q;

  // ----------------------------------------
  // speed loop arithmetic
  // ----------------------------------------
  logic signed [23:0] meas_q; // measured speed
  logic signed [23:0] req_q; // ramp output
  logic signed [23:0] integ_q; // integral state
  logic signed [23:0] scOut_q; // new applied voltage
  logic [23:0] timeDiff; // time between sampled edges
  logic signed [47:0] measQuo; // scaled counts per time
  logic signed [24:0] rampErr; // distance to ramp input
  logic signed [47:0] piErr; // control error
  logic signed [47:0] pTerm; // proportional part
  logic signed [47:0] iStep; // integral increment
  logic signed [23:0] integNext; // integral after step

  assign timeDiff = lastEdge_q - prevEdge_q;
  // divider is costly but runs once per speed run; zero time reads as stopped
  assign measQuo = (timeDiff == 24'h000000) ? 48'sh000000000000 :
                   (48'(pcSc_q) * 48'(speedScale)) / $signed({24'h000000, timeDiff});
  assign rampErr = 25'(speedRequired) - 25'(req_q);
  assign piErr = 48'(sat24(48'(req_q) - 48'(meas_q)));
  assign pTerm = (48'(gainP) * piErr) >>> GAIN_FRAC;
  assign iStep = (48'(gainI) * piErr) >>> GAIN_FRAC;
  assign integNext = sat24(48'(integ_q) + iStep);

  // measure, ramp and controller steps, one per service cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_q <= 24'sh000000;
      req_q <= 24'sh000000;
      integ_q <= 24'sh000000;
      scOut_q <= 24'sh000000;
    end else begin
      case (state_q)
        ST_SC_MEAS: meas_q <= sat24(measQuo);
        ST_SC_RAMP: begin
          // limited step toward the requested speed
          if (rampErr > 25'(rampStep)) begin
            req_q <= req_q + rampStep;
          end else if (rampErr < -25'(rampStep)) begin
            req_q <= req_q - rampStep;
          end else begin
            req_q <= speedRequired;
          end
        end
        ST_SC_PI: begin
          if (loopClosed) begin
            integ_q <= integNext;
            scOut_q <= sat24(pTerm + 48'(integNext));
          end else begin
            scOut_q <= req_q; // open loop passes the ramp through
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign measuredSpeed = meas_q;

  // ----------------------------------------
  // pwm master: accept and per frame update
  // ----------------------------------------
  logic signed [23:0] volt_q; // accepted voltage
  logic [CNT_W-1:0] dutyShadow_q; // duty handed to all phases
  logic [31:0] dutyProd; // voltage times half frame

  assign dutyProd = {9'h000, volt_q[22:0]} * {23'h000000, HALF};

  // voltage hand-over; accept sets pending, rewrite clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_q <= 24'sh000000;
      voltNew_q <= 1'b0;
      dutyShadow_q <= DUTY_RST;
    end else begin
      if (state_q == ST_MS_ACCEPT) begin
        volt_q <= scOut_q;
        voltNew_q <= 1'b1;
      end else if (state_q == ST_MS_WRITE) begin
        voltNew_q <= 1'b0;
        // negative voltage reads as zero duty in this variant
        dutyShadow_q <= volt_q[23] ? DUTY_RST : dutyProd[VOLT_FRAC +: CNT_W];
      end
    end
  end

  assign appliedVoltage = volt_q;

  // ----------------------------------------
  // phases and fault cut-off
  // ----------------------------------------
  logic [2:0] baseRaw; // phase outputs before fault gate
  logic [2:0] complRaw;
  logic [2:0] faultCut; // phases forced off

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      bslc_phase #(
        .PERIOD(PERIOD_CYC)
      ) u_phase (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .frameCnt(frameCnt_q),
        .frameEnd(frameEnd),
        .dutyShadow(dutyShadow_q),
        .phaseOn(phaseOn[ph] & driveEnable),
        .complPair(complPairs),
        .baseOut(baseRaw[ph]),
        .complOut(complRaw[ph])
      );
    end
  endgenerate

  // combinational gate: cuts the same cycle the fault arrives
  assign faultCut = faultMask & {3{faultIn}};
  assign pwmBase = baseRaw & ~faultCut;
  assign pwmCompl = complRaw & ~faultCut;

  logic faultPrev_q; // last fault level

  // fault interrupt, a new fault wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultPrev_q <= 1'b0;
      faultIrq <= 1'b0;
    end else begin
      faultPrev_q <= faultIn;
      faultIrq <= (faultIn & ~faultPrev_q) | (faultIrq & ~faultIrqClear);
    end
  end

  // ----------------------------------------
  // general purpose channel
  // ----------------------------------------
  logic gpioPrev_q; // last input level
  logic gpioUpd; // sample input now

  always_comb begin
    case (gpioMode)
      GPIO_PERIODIC: gpioUpd = frameEnd;
      GPIO_ANY_EDGE: gpioUpd = gpioIn ^ gpioPrev_q;
      GPIO_FALL: gpioUpd = gpioPrev_q & ~gpioIn;
      GPIO_RISE: gpioUpd = gpioIn & ~gpioPrev_q;
      GPIO_ON_REQ: gpioUpd = gpioRequest;
      default: gpioUpd = 1'b0;
    endcase
  end

  // input sampling and output drive
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpioPrev_q <= 1'b0;
      gpioValue <= 1'b0;
      gpioOut <= 1'b0;
      gpioOe_n <= 1'b1;
    end else begin
      gpioPrev_q <= gpioIn;
      if (gpioUpd) begin
        gpioValue <= gpioIn;
      end
      gpioOut <= (gpioMode == GPIO_OUT_HIGH);
      gpioOe_n <= !((gpioMode == GPIO_OUT_LOW) || (gpioMode == GPIO_OUT_HIGH));
    end
  end

endmodule

`default_nettype wire

// [logic/bslc_phase.sv]
// Purpose: one commuted, center-aligned pwm phase
// Assumes: frame counter shared from the engine
// Notes: duty loads only at frame end, so no pulse is cut
`timescale 1ns/1ps
`default_nettype none

module bslc_phase import bslc_pkg::*; #(
  parameter int PERIOD = PWM_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [CNT_W-1:0] frameCnt,
  input wire logic frameEnd,
  input wire logic [CNT_W-1:0] dutyShadow,
  input wire logic phaseOn,
  input wire logic complPair,
  output logic baseOut,
  output logic complOut
);

  localparam logic [CNT_W-1:0] HALF = CNT_W'(PERIOD / 2); // frame center

  logic [CNT_W-1:0] duty_q; // duty in force this frame
  logic active; // base pulse window

  // ----------------------------------------
  // duty load at frame boundary
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= DUTY_RST;
    end else if (frameEnd) begin
      duty_q <= dutyShadow;
    end
  end

  // symmetric window around frame center
  always_comb begin
    if (frameCnt < HALF) begin
      active = (frameCnt >= HALF - duty_q);
    end else begin
      active = (frameCnt < HALF + duty_q);
    end
  end

  // ----------------------------------------
  // outputs, off state drives both low
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      baseOut <= 1'b0;
      complOut <= 1'b0;
    end else begin
      baseOut <= phaseOn & active;
      // complementary lane is active high: high while base is low, in pair mode only
      complOut <= phaseOn & complPair & ~active;
    end
  end

endmodule

`default_nettype wire

// [logic/bslc_pkg.sv]
// Purpose: shared constants and types of the motor timing engine
// Assumes: 10 MHz engine clock, 20 kHz pwm frame
// Notes: all times in ns, counts derived from the clock period
`default_nettype none

package bslc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100; // ref_clk period
  localparam int PWM_PERIOD_NS = 50000; // 20 kHz frame
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SC_PERIOD_DIV = 40; // speed loop every 40th frame, 500 Hz
  localparam int UPDATE_LEAD_NS = 5000; // master update lead before frame end
  localparam int UPDATE_LEAD_CYC = UPDATE_LEAD_NS / CLK_PERIOD_NS; // longest, rounds down
  localparam int SC_START_NS = 20000; // speed loop offset into frame
  localparam int SC_START_CYC = (SC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // widths and formats
  // ----------------------------------------
  localparam int CNT_W = 9; // frame counter and duty width
  localparam int POS_W = 24; // position counter
  localparam int REV_CNT_W = 16; // revolution counter
  localparam int GAIN_FRAC = 15; // gains in 9.15
  localparam int VOLT_FRAC = 23; // quantities in 1.23

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [CNT_W-1:0] DUTY_RST = 9'h000;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SC_MEAS = 3'h1,
    ST_SC_RAMP = 3'h2,
    ST_SC_PI = 3'h3,
    ST_MS_ACCEPT = 3'h4,
    ST_MS_WRITE = 3'h5,
    ST_MS_UPD = 3'h6
  } bslc_state_e;

  typedef enum logic [2:0] {
    GPIO_PERIODIC = 3'h0,
    GPIO_ANY_EDGE = 3'h1,
    GPIO_FALL = 3'h2,
    GPIO_RISE = 3'h3,
    GPIO_ON_REQ = 3'h4,
    GPIO_OUT_LOW = 3'h5,
    GPIO_OUT_HIGH = 3'h6
  } bslc_gpio_e;

endpackage

`default_nettype wire

// [testbench/bslc_encoder.sv]
// Purpose: shaft encoder model, quadrature pair and index
// Assumes: one step per request pulse
// Notes: B leads A when turning forward
`timescale 1ns/1ps
`default_nettype none
module bslc_encoder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stepFwd,
  input wire logic stepRev,
  input wire logic indexReq,
  output logic qdPhaseA,
  output logic qdPhaseB,
  output logic qdIndex
);
  logic [1:0] phase_q; // binary position of the disc, gray coded onto A and B
  // ----------------------------------------
  // disc motion
  // ----------------------------------------
  // a single step request moves one position, so one line changes per edge; both requests at once jump two
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      qdIndex <= 1'b0;
    end else begin
      phase_q <= phase_q + {stepRev, stepFwd ^ stepRev};
      qdIndex <= indexReq;
    end
  end
  assign qdPhaseA = phase_q[1];
  assign qdPhaseB = phase_q[1] ^ phase_q[0];
endmodule
`default_nettype wire

// [testbench/bslc_engine_bench.sv]
// Purpose: self-checking bench of the timing engine
// Assumes: shortened frame of 40 cycles, loop every 4th frame
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module bslc_engine_bench;
  import bslc_pkg::*;
  logic ref_clk = 0, rst_n = 0, driveEnable = 1, complPairs = 0, faultIn = 0;
  logic posIrqClear = 0, faultIrqClear = 0, gpioIn = 0, gpioRequest = 0, loopClosed = 0;
  logic signed [23:0] speedRequired = 24'sh200000, gainP = 24'sh008000, gainI = 24'sh004000;
  logic stepFwd = 0, stepRev = 0, indexReq = 0, qdPhaseA, qdPhaseB, qdIndex;
  logic [2:0] phaseOn = 3'h7, faultMask = 3'h5, gpioMode = 3'h7, pwmBase, pwmCompl;
  logic [23:0] posMatchA = 24'h000005, posMatchB = 24'h000004, position;
  logic scActivity, masterActivity, direction, posIrq, faultIrq, gpioOut, gpioOe_n, gpioValue;
  logic [15:0] revCount;
  logic signed [23:0] measuredSpeed, appliedVoltage;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  always #50 ref_clk = ~ref_clk;
  bslc_engine #(.PERIOD_CYC(40), .SC_DIV(4), .LEAD_CYC(8), .SC_START(10)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .driveEnable(driveEnable), .loopClosed(loopClosed),
    .complPairs(complPairs), .phaseOn(phaseOn), .speedRequired(speedRequired),
    .rampStep(24'sh100000), .gainP(gainP), .gainI(gainI),
    .speedScale(24'sh100000), .qdPhaseA(qdPhaseA), .qdPhaseB(qdPhaseB), .qdIndex(qdIndex),
    .posMatchA(posMatchA), .posMatchB(posMatchB), .posIrqClear(posIrqClear),
    .faultIn(faultIn), .faultMask(faultMask), .faultIrqClear(faultIrqClear),
    .gpioMode(gpioMode), .gpioIn(gpioIn), .gpioRequest(gpioRequest), .pwmBase(pwmBase),
    .pwmCompl(pwmCompl), .scActivity(scActivity), .masterActivity(masterActivity),
    .position(position), .direction(direction), .revCount(revCount),
    .measuredSpeed(measuredSpeed), .appliedVoltage(appliedVoltage), .posIrq(posIrq),
    .faultIrq(faultIrq), .gpioOut(gpioOut), .gpioOe_n(gpioOe_n), .gpioValue(gpioValue));
  bslc_encoder enc_u (.ref_clk(ref_clk), .rst_n(rst_n), .stepFwd(stepFwd), .stepRev(stepRev),
    .indexReq(indexReq), .qdPhaseA(qdPhaseA), .qdPhaseB(qdPhaseB), .qdIndex(qdIndex));
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // wait for the next speed run and its accept to finish
  task automatic next_run;
    while (scActivity !== 1'b1) tick(1);
    tick(5);
  endtask
  // run length, accept, ramp limit, shared duty, commutation, closed loop
  task automatic t_speed;
    int hi[3];
    int bad;
    while (scActivity !== 1'b1) tick(1);
    tick(3);
    `CHK(scActivity, 1'b0)
    `CHK(masterActivity, 1'b1)
    tick(2);
    `CHK(appliedVoltage, 24'sh100000)
    next_run();
    `CHK(appliedVoltage, 24'sh200000)
    complPairs = 1;
    tick(40);
    for (int r = 0; r < 2; r++) begin
      hi = '{0, 0, 0};
      bad = 0;
      for (int c = 0; c < 40; c++) begin
        for (int p = 0; p < 3; p++) begin
          hi[p] += pwmBase[p];
          bad += (pwmCompl[p] !== (phaseOn[p] & ~pwmBase[p]));
        end
        tick(1);
      end
      for (int p = 0; p < 3; p++) `CHK(hi[p], phaseOn[p] ? 10 : 0)
      `CHK(bad, 0)
      phaseOn = 3'h2;
      tick(2);
    end
    phaseOn = 3'h7;
    loopClosed = 1;
    next_run();
    `CHK(appliedVoltage, 24'sh300000)
    speedRequired = 24'sh000000;
    gainP = 24'sh004000;
    gainI = 24'sh000000;
    next_run();
    `CHK(appliedVoltage, 24'sh180000)
    loopClosed = 0;
    speedRequired = 24'sh200000;
    next_run();
    `CHK(appliedVoltage, 24'sh200000)
    $display("speed test done");
  endtask
  // counting, direction, revolutions and match interrupt
  task automatic t_decoder;
    repeat (5) begin stepFwd = 1; tick(1); stepFwd = 0; tick(3); end
    `CHK(position, 24'h000005)
    `CHK(direction, 1'b1)
    next_run();
    `CHK(measuredSpeed > 24'sh000000, 1'b1)
    indexReq = 1; tick(1); indexReq = 0; tick(4);
    `CHK(revCount, 16'h0001)
    `CHK(posIrq, 1'b1)
    posIrqClear = 1; tick(2); posIrqClear = 0; tick(1);
    `CHK(posIrq, 1'b0)
    stepRev = 1; tick(1); stepRev = 0; tick(4);
    `CHK(position, 24'h000004)
    `CHK(direction, 1'b0)
    `CHK(posIrq, 1'b1)
    indexReq = 1; tick(1); indexReq = 0; tick(4);
    `CHK(revCount, 16'h0000)
    $display("decoder test done");
  endtask
  // every general channel mode: {mode, input, request, value}
  task automatic t_gpio;
    logic [5:0] rows[9] = '{6'h0d, 6'h10, 6'h1d, 6'h19, 6'h21, 6'h22, 6'h05, 6'h28, 6'h31};
    foreach (rows[i]) begin
      gpioMode = rows[i][5:3];
      gpioIn = rows[i][2];
      gpioRequest = rows[i][1];
      tick(1);
      gpioRequest = 0;
      tick(44);
      if (gpioMode < 3'h5) `CHK(gpioValue, rows[i][0])
      else `CHK({gpioOut, gpioOe_n}, {rows[i][0], 1'b0})
    end
    $display("gpio test done");
  endtask
  // immediate cut of masked phases and interrupt on the next edge
  task automatic t_fault;
    while (pwmBase[1] !== 1'b1) tick(1);
    faultIn = 1;
    #1;
    `CHK(pwmBase, 3'h2)
    faultMask = 3'h2;
    #1;
    `CHK(pwmBase, 3'h5)
    tick(1);
    `CHK(faultIrq, 1'b1)
    faultIn = 0; faultIrqClear = 1; tick(2); faultIrqClear = 0; tick(1);
    `CHK(faultIrq, 1'b0)
    $display("fault test done");
  endtask
  // mid-run reset: outputs back to idle, frame timing restarts
  task automatic t_reset;
    rst_n = 0;
    #1;
    `CHK({position, direction, posIrq, gpioOe_n}, {24'h000000, 3'h5})
    `CHK(appliedVoltage, 24'sh000000)
    tick(3);
    rst_n = 1;
    tick(11);
    `CHK(scActivity, 1'b0)
    tick(1);
    `CHK(scActivity, 1'b1)
    $display("reset test done");
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    tick(3);
    rst_n = 1;
    t_speed();
    t_decoder();
    t_gpio();
    t_fault();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire

// [testbench/bslc_engine_chk.sv]
// Purpose: port checker of the timing engine
// Assumes: driveEnable stays high once up
// Notes: period check needs two runs seen
`timescale 1ns/1ps
`default_nettype none
module bslc_engine_chk #(
  parameter int PERIOD_CYC = 500,
  parameter int SC_DIV = 40
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic complPairs,
  input wire logic faultIn,
  input wire logic [2:0] faultMask,
  input wire logic [23:0] posMatchA,
  input wire logic [23:0] posMatchB,
  input wire logic [2:0] pwmBase,
  input wire logic [2:0] pwmCompl,
  input wire logic scActivity,
  input wire logic masterActivity,
  input wire logic [23:0] position,
  input wire logic posIrq,
  input wire logic faultIrq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] gap_q; // cycles since last speed run start
  logic seen_q; // one run already observed
  logic scPrev_q; // activity level one cycle back
  // ----------------------------------------
  // run spacing counter
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
      scPrev_q <= 1'b0;
    end else begin
      scPrev_q <= scActivity;
      // explicit edge: no sampled-value call under the async reset
      if (scActivity && !scPrev_q) begin
        gap_q <= 16'h0000;
        seen_q <= 1'b1;
      end else begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end
  a_sc_pulse_len: assert property ($rose(scActivity) |-> scActivity[*3] ##1 !scActivity)
    else $error("speed activity not three cycles");
  a_accept_after: assert property ($fell(scActivity) |-> masterActivity)
    else $error("no accept after speed run");
  a_sc_period: assert property ($rose(scActivity) && seen_q |-> gap_q == PERIOD_CYC * SC_DIV - 1)
    else $error("speed run spacing wrong");
  a_no_preempt: assert property (!(scActivity && masterActivity))
    else $error("two services at once");
  a_master_len: assert property ($rose(masterActivity) |-> ##[1:2] !masterActivity)
    else $error("master service too long");
  a_fault_cut: assert property (((faultMask & {3{faultIn}}) & (pwmBase | pwmCompl)) == 3'h0)
    else $error("faulted phase still driven");
  a_fault_irq: assert property ($rose(faultIn) |=> faultIrq)
    else $error("fault interrupt missing");
  a_single_lane: assert property (!complPairs |-> pwmCompl == 3'h0)
    else $error("compl lane driven in single mode");
  a_pos_step: assert property ($changed(position) |-> (position - $past(position)) inside {24'h000001, 24'hffffff})
    else $error("position jumped");
  a_pos_match: assert property ($changed(position) && (position == posMatchA || position == posMatchB) |-> posIrq)
    else $error("position match missed");
  c_sc_run: cover property ($fell(scActivity));
  c_fault: cover property ($rose(faultIrq));
  c_match: cover property ($rose(posIrq));
endmodule
bind bslc_engine bslc_engine_chk #(.PERIOD_CYC(PERIOD_CYC), .SC_DIV(SC_DIV)) chk_u (.*);
`default_nettype wire
